/* core/swt_stopwatch.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// - count register holds hundredths BCD in low nibble, tenths BCD in high nibble.
// - count register is read-only; writes leave the count unchanged.
// - initial reset clears both BCD digits.
// - writing one to clear-count resets both digits; zero does nothing; reads zero.
// - clear while running resumes from zero; clear while stopped holds zero.
// - run-control bit one counts up, zero stops; reads back its state.
// - stopped count is held until cleared; run resumes from the held value.
// - run-control bit resets to zero.
// - two-bit priority field gives levels 0 to 3 and resets to zero.
// - three enable bits gate 1 Hz, 10 Hz and 100 Hz sources; reset zero.
// - each flag sets on the falling edge of its 1, 10 or 100 Hz signal.
// - flags set regardless of enable bits and priority.
// - request raised when flag, enable set and priority above CPU mask level.
// - writing one clears a flag, zero leaves it; reads show the flag.
// - initial reset clears all three flags.
// - divider makes a 100 Hz tick from 256 Hz with 2/256 and 3/256 intervals.
// - tenths digit counts the hundredths carry, making a 1 Hz signal.
// - run changes take effect on the next 256 Hz falling edge; bit reads one until then.
// - 100 Hz, 10 Hz and 1 Hz interrupts use vectors 16h, 18h and 1ah.
module swt_stopwatch
  import swt_pkg::*;
#(
  parameter int TICK_CYC = SWT_TICK_CYC
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [1:0] cpu_mask_level_i,
  output logic irq_o,
  output logic [1:0] irq_level_o,
  output logic [23:0] irq_vector_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [$clog2(TICK_CYC)-1:0] pre_r;
  logic tick256;
  logic [2:0] fb_r;
  logic tick100;
  logic [3:0] hundredths_digit_r;
  logic [3:0] tenths_digit_r;
  logic run_control_bit_r;
  logic run_active_r;
  logic [1:0] chrono_priority_r;
  logic [2:0] src_enable_r;
  logic [2:0] src_flag_r;
  logic [2:0] src_event;
  logic [2:0] src_pend;
  logic wr_ctrl;
  logic wr_flag;
  logic carry10;
  logic carry1;
  logic [7:0] rdata_nxt;

  assign wr_ctrl = wr_i && (addr_i == SWT_ADDR_CTRL);
  assign wr_flag = wr_i && (addr_i == SWT_ADDR_FLAG);

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------

  // Prescaler standing in for the falling edge of the 256 Hz signal.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pre_r <= '0;
    else if (pre_r == ($clog2(TICK_CYC))'(TICK_CYC - 1))
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;
  end

  assign tick256 = (pre_r == ($clog2(TICK_CYC))'(TICK_CYC - 1));

  // Feedback divider: 100 Hz tick every 2 or 3 ticks alternately.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      fb_r <= 3'h0;
    else if (wr_ctrl && wdata_i[SWT_CLR_BIT])
      fb_r <= 3'h0;
    else if (tick256 && run_active_r)
    begin
      if (fb_r == 3'h4)
        fb_r <= 3'h0;
      else
        fb_r <= fb_r + 3'h1;
    end
  end

  // Five-tick cycle with pulses on phases 1 and 4: intervals of 2 then 3 ticks.
  assign tick100 = tick256 && run_active_r && (fb_r == 3'h1 || fb_r == 3'h4);

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------

  // Software view of the run bit.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      run_control_bit_r <= 1'b0;
    else if (wr_ctrl)
      run_control_bit_r <= wdata_i[SWT_RUN_BIT];
  end

  // Effective run state follows the request only on a 256 Hz edge.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      run_active_r <= 1'b0;
    else if (tick256)
      run_active_r <= run_control_bit_r;
  end

  // ------------------------------------------------------------
  // BCD counters
  // ------------------------------------------------------------
  assign carry10 = tick100 && (hundredths_digit_r == SWT_DIGIT_MAX);
  assign carry1 = carry10 && (tenths_digit_r == SWT_DIGIT_MAX);

  // Hundredths digit counts the 100 Hz tick.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      hundredths_digit_r <= SWT_CNT_RST[3:0];
    else if (wr_ctrl && wdata_i[SWT_CLR_BIT])
      hundredths_digit_r <= 4'h0;
    else if (carry10)
      hundredths_digit_r <= 4'h0;
    else if (tick100)
      hundredths_digit_r <= hundredths_digit_r + 4'h1;
  end

  // Tenths digit counts the hundredths carry.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tenths_digit_r <= SWT_CNT_RST[7:4];
    else if (wr_ctrl && wdata_i[SWT_CLR_BIT])
      tenths_digit_r <= 4'h0;
    else if (carry1)
      tenths_digit_r <= 4'h0;
    else if (carry10)
      tenths_digit_r <= tenths_digit_r + 4'h1;
  end

  // ------------------------------------------------------------
  // Interrupt control
  // ------------------------------------------------------------

  // Priority and enable registers.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      chrono_priority_r <= SWT_PRIO_RST;
      src_enable_r <= SWT_SRC_RST;
    end
    else
    begin
      if (wr_i && addr_i == SWT_ADDR_PRIO)
        chrono_priority_r <= wdata_i[SWT_PRIO_LSB +: 2];
      if (wr_i && addr_i == SWT_ADDR_IEN)
        src_enable_r <= wdata_i[SWT_SRC_LSB +: 3];
    end
  end

  // Falling edges of 1 Hz, 10 Hz, 100 Hz signals: the two digit wraps and the 100 Hz tick.
  assign src_event = {tick100, carry10, carry1};

  // Sticky flags, one per source; a set wins over a same-cycle clear.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_flag
      always_ff @(posedge mclk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          src_flag_r[gi] <= 1'b0;
        else if (src_event[gi])
          src_flag_r[gi] <= 1'b1;
        else if (wr_flag && wdata_i[SWT_SRC_LSB + gi])
          src_flag_r[gi] <= 1'b0;
      end
    end
  endgenerate

  assign src_pend = src_flag_r & src_enable_r;

  // Request when any enabled flag and priority beats the mask.
  assign irq_o = (|src_pend) && (chrono_priority_r > cpu_mask_level_i);
  assign irq_level_o = chrono_priority_r;

  // Highest-rate pending source selects the vector.
  always_comb
  begin
    if (src_pend[2])
      irq_vector_o = SWT_VEC_100HZ;
    else if (src_pend[1])
      irq_vector_o = SWT_VEC_10HZ;
    else
      irq_vector_o = SWT_VEC_1HZ;
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (addr_i)
      SWT_ADDR_PRIO: rdata_nxt = {4'h0, chrono_priority_r, 2'h0};
      SWT_ADDR_IEN: rdata_nxt = {1'b0, src_enable_r, 4'h0};
      SWT_ADDR_FLAG: rdata_nxt = {1'b0, src_flag_r, 4'h0};
      SWT_ADDR_CTRL: rdata_nxt = {7'h00, run_control_bit_r | run_active_r};
      SWT_ADDR_CNT: rdata_nxt = {tenths_digit_r, hundredths_digit_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stand one cycle after the strobe and only then.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rdata_nxt;
    else
      rdata_o <= 8'h00;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_clear_wr;
    wr_ctrl && wdata_i[SWT_CLR_BIT];
  endsequence

  property p_clear;
    @(posedge mclk_i) disable iff (!arst_n_i)
      s_clear_wr |=> (hundredths_digit_r == 4'h0 && tenths_digit_r == 4'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");

  property p_bcd;
    @(posedge mclk_i) disable iff (!arst_n_i)
      hundredths_digit_r <= 4'h9 && tenths_digit_r <= 4'h9;
  endproperty
  a_bcd: assert property (p_bcd) else $error("digit out of bcd range");

  property p_hold;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (!run_active_r && !(wr_ctrl && wdata_i[SWT_CLR_BIT])) |=> $stable(hundredths_digit_r);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");

  property p_run_sync;
    @(posedge mclk_i) disable iff (!arst_n_i)
      $changed(run_active_r) |-> $past(tick256);
  endproperty
  a_run_sync: assert property (p_run_sync) else $error("run changed off tick");

  property p_flag_set;
    @(posedge mclk_i) disable iff (!arst_n_i)
      carry10 |=> src_flag_r[1];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("10 Hz flag not set");

  property p_flag_clr;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (wr_flag && wdata_i[6] && !tick100) |=> !src_flag_r[2];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_irq;
    @(posedge mclk_i) disable iff (!arst_n_i)
      irq_o |-> (chrono_priority_r > cpu_mask_level_i) && |(src_flag_r & src_enable_r);
  endproperty
  a_irq: assert property (p_irq) else $error("bad interrupt request");

  property p_cnt_read;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == SWT_ADDR_CNT) |=>
        rdata_o == {$past(tenths_digit_r), $past(hundredths_digit_r)};
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read mismatch");

  // Assertion helper: run ticks since the last 100 Hz tick, and whether the last
  // interval was the long one, so the alternation is checked apart from the divider.
  logic [1:0] gap_r;
  logic last_long_r;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gap_r <= 2'h0;
      last_long_r <= 1'b1;
    end
    else if (wr_ctrl && wdata_i[SWT_CLR_BIT])
    begin
      gap_r <= 2'h0;
      last_long_r <= 1'b1;
    end
    else if (tick100)
    begin
      gap_r <= 2'h0;
      last_long_r <= (gap_r == 2'h2);
    end
    else if (tick256 && run_active_r)
      gap_r <= gap_r + 2'h1;
  end

  property p_div_gap;
    @(posedge mclk_i) disable iff (!arst_n_i)
      tick100 |-> (last_long_r ? (gap_r == 2'h1) : (gap_r == 2'h2));
  endproperty
  a_div_gap: assert property (p_div_gap) else $error("100 Hz interval out of order");

  property p_cnt_ro;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (wr_i && addr_i == SWT_ADDR_CNT && !tick100) |=>
        $stable({tenths_digit_r, hundredths_digit_r});
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("count written");

  property p_run_read;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == SWT_ADDR_CTRL && run_active_r) |=> rdata_o[SWT_RUN_BIT];
  endproperty
  a_run_read: assert property (p_run_read) else $error("run bit read low while running");

  property p_clr_read;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == SWT_ADDR_CTRL) |=> !rdata_o[SWT_CLR_BIT];
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("clear bit read high");

endmodule

/* core/swt_pkg.sv */
package swt_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [23:0] SWT_ADDR_PRIO = 24'h00ff20;
  localparam logic [23:0] SWT_ADDR_IEN = 24'h00ff22;
  localparam logic [23:0] SWT_ADDR_FLAG = 24'h00ff24;
  localparam logic [23:0] SWT_ADDR_CTRL = 24'h00ff42;
  localparam logic [23:0] SWT_ADDR_CNT = 24'h00ff43;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SWT_RUN_BIT = 0;
  localparam int SWT_CLR_BIT = 1;
  localparam int SWT_PRIO_LSB = 2;
  localparam int SWT_SRC_LSB = 4;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] SWT_CNT_RST = 8'h00;
  localparam logic [1:0] SWT_PRIO_RST = 2'h0;
  localparam logic [2:0] SWT_SRC_RST = 3'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SWT_TICK_HZ = 256;
  localparam int SWT_CLK_HZ = 125000000;
  localparam int SWT_TICK_CYC = SWT_CLK_HZ / SWT_TICK_HZ;
  localparam logic [3:0] SWT_DIGIT_MAX = 4'h9;

  // ------------------------------------------------------------
  // Exception vectors (index 0: 1 Hz, 1: 10 Hz, 2: 100 Hz)
  // ------------------------------------------------------------
  localparam logic [23:0] SWT_VEC_100HZ = 24'h000016;
  localparam logic [23:0] SWT_VEC_10HZ = 24'h000018;
  localparam logic [23:0] SWT_VEC_1HZ = 24'h00001a;

endpackage

/* test/swt_cpu_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// CPU interrupt acceptance model
// ------------------------------------------------------------
module swt_cpu_model
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic irq_i,
  input wire logic [1:0] irq_level_i,
  input wire logic return_from_exception_i,
  output logic [1:0] cpu_mask_level_o
);
  // Taking a request raises the mask to its level, so the line drops until released.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cpu_mask_level_o <= 2'h0;
    else if (return_from_exception_i)
      cpu_mask_level_o <= 2'h0;
    else if (irq_i)
      cpu_mask_level_o <= irq_level_i;
  end
endmodule

/* test/swt_stopwatch_test.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Stopwatch block bench
// ------------------------------------------------------------
module swt_stopwatch_test;
  import swt_pkg::*;
  localparam int TCYC = 4;
  logic mclk, arst_n, wr, rd, return_from_exception, irq;
  logic [23:0] addr, vec;
  logic [7:0] wdata, rdata, d, e;
  logic [1:0] mask, lvl;
  int fails, checked;

  swt_stopwatch #(.TICK_CYC(TCYC)) swt_stopwatch_inst (.mclk_i(mclk), .arst_n_i(arst_n),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .cpu_mask_level_i(mask), .irq_o(irq), .irq_level_o(lvl), .irq_vector_o(vec));
  swt_cpu_model swt_cpu_model_inst (.mclk_i(mclk), .arst_n_i(arst_n), .irq_i(irq),
    .irq_level_i(lvl), .return_from_exception_i(return_from_exception), .cpu_mask_level_o(mask));

  // The clock toggles every half period of 4 ns.
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Compares a value and counts the outcome.
  task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
    checked++;
    if (g !== x)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr_reg(input logic [23:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; data is taken in the following cycle only.
  task automatic rd_reg(input logic [23:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Waits a bounded time for a request.
  task automatic wait_irq();
    int i;
    for (i = 0; i < 200 && irq !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    if (irq !== 1'b1)
    begin
      fails++;
      $display("Error irq_o wait expected 1 seen %b", irq);
      close_out();
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Every register and an unmapped address read zero after reset.
  task automatic t_reset();
    logic [23:0] m [6];
    m = '{SWT_ADDR_PRIO, SWT_ADDR_IEN, SWT_ADDR_FLAG, SWT_ADDR_CTRL, SWT_ADDR_CNT, 24'h00ff21};
    foreach (m[i])
    begin
      rd_reg(m[i], d);
      chk("reset value", 24'h0, {16'h0, d});
    end
    $display("t_reset done");
  endtask

  // Read/write fields, write-only clear and read-only count.
  task automatic t_regs();
    wr_reg(SWT_ADDR_PRIO, 8'h0c);
    rd_reg(SWT_ADDR_PRIO, d);
    chk("priority", 24'h0c, {16'h0, d});
    wr_reg(SWT_ADDR_IEN, 8'h70);
    rd_reg(SWT_ADDR_IEN, d);
    chk("enables", 24'h70, {16'h0, d});
    wr_reg(SWT_ADDR_CTRL, 8'h02);
    rd_reg(SWT_ADDR_CTRL, d);
    chk("control", 24'h0, {16'h0, d});
    wr_reg(SWT_ADDR_CNT, 8'hff);
    rd_reg(SWT_ADDR_CNT, d);
    chk("count", 24'h0, {16'h0, d});
    wr_reg(SWT_ADDR_PRIO, 8'h00);
    wr_reg(SWT_ADDR_IEN, 8'h00);
    $display("t_regs done");
  endtask

  // Run past one full second, then stop, hold and clear.
  task automatic t_run();
    wr_reg(SWT_ADDR_CTRL, 8'h01);
    idle(260 * TCYC);
    rd_reg(SWT_ADDR_FLAG, d);
    chk("flags", 24'h70, {16'h0, d});
    chk("irq_o disabled", 24'h0, {23'h0, irq});
    wr_reg(SWT_ADDR_IEN, 8'h30);
    #1 chk("vector 10 Hz", SWT_VEC_10HZ, vec);
    wr_reg(SWT_ADDR_IEN, 8'h10);
    #1 chk("vector 1 Hz", SWT_VEC_1HZ, vec);
    chk("irq_o level 0", 24'h0, {23'h0, irq});
    wr_reg(SWT_ADDR_IEN, 8'h00);
    rd_reg(SWT_ADDR_CTRL, d);
    chk("run bit", 24'h1, {16'h0, d});
    rd_reg(SWT_ADDR_CNT, d);
    chk("bcd digits", 24'h1, {23'h0, d[3:0] <= 4'h9 && d[7:4] <= 4'h9});
    wr_reg(SWT_ADDR_CTRL, 8'h00);
    idle(5 * TCYC);
    rd_reg(SWT_ADDR_CNT, d);
    idle(20 * TCYC);
    rd_reg(SWT_ADDR_CNT, e);
    chk("held count", {16'h0, d}, {16'h0, e});
    rd_reg(SWT_ADDR_CTRL, d);
    chk("run bit", 24'h0, {16'h0, d});
    wr_reg(SWT_ADDR_CTRL, 8'h02);
    idle(10 * TCYC);
    rd_reg(SWT_ADDR_CNT, d);
    chk("cleared count", 24'h0, {16'h0, d});
    $display("t_run done");
  endtask

  // Counts from zero for a fixed time; alternating 2/3 tick intervals give exactly 20.
  task automatic t_pace();
    wr_reg(SWT_ADDR_CTRL, 8'h01);
    idle(51 * TCYC + 1);
    rd_reg(SWT_ADDR_CNT, d);
    chk("paced count", 24'h20, {16'h0, d});
    wr_reg(SWT_ADDR_CTRL, 8'h03);
    idle(50 * TCYC + 1);
    rd_reg(SWT_ADDR_CNT, d);
    chk("count after running clear", 24'h20, {16'h0, d});
    wr_reg(SWT_ADDR_CTRL, 8'h00);
    idle(2 * TCYC);
    $display("t_pace done");
  endtask

  // Request, acceptance by mask, flag clear and release.
  task automatic t_irq();
    wr_reg(SWT_ADDR_FLAG, 8'h70);
    rd_reg(SWT_ADDR_FLAG, d);
    chk("flags cleared", 24'h0, {16'h0, d});
    wr_reg(SWT_ADDR_PRIO, 8'h08);
    wr_reg(SWT_ADDR_IEN, 8'h40);
    wr_reg(SWT_ADDR_CTRL, 8'h03);
    wait_irq();
    chk("vector", SWT_VEC_100HZ, vec);
    chk("level", 24'h2, {22'h0, lvl});
    @(posedge mclk);
    #1 chk("irq_o masked", 24'h0, {23'h0, irq});
    wr_reg(SWT_ADDR_FLAG, 8'h40);
    @(posedge mclk);
    return_from_exception <= 1'b1;
    @(posedge mclk);
    return_from_exception <= 1'b0;
    wait_irq();
    chk("irq_o again", 24'h1, {23'h0, irq});
    wr_reg(SWT_ADDR_CTRL, 8'h00);
    $display("t_irq done");
  endtask

  initial
  begin
    fails = 0;
    checked = 0;
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    return_from_exception = 1'b0;
    addr = 24'h0;
    wdata = 8'h00;
    idle(4);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_run();
    t_pace();
    t_irq();
    close_out();
  end
endmodule
